// ---- rtl/crs_crtc_timing.sv ----
/*
 Horizontal sync start/end/delay, 10-bit vertical total with overflow
 register, preset row scan and coarse byte pan of the CRT timing generator.
 Assumes the character and scanline counters, horizontal total and the
 rest of the timing chain live elsewhere and feed this block.
*/
`timescale 1ns/1ps
module crs_crtc_timing
	import crs_pkg::*;
#(
	parameter int HCNT_W = 8,
	parameter int VCNT_W = 10
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire crs_regreq_s       regReq,
	output logic [7:0]             regRdata,
	output logic                   regHit,
	input  wire logic              charTick,
	input  wire logic [HCNT_W-1:0] charCount,
	input  wire logic              lineTick,
	input  wire logic [VCNT_W-1:0] scanCount,
	output logic                   hsyncInt,
	output logic                   hsyncExt,
	output logic                   vretraceStart,
	output logic [VCNT_W-1:0]      vtotal,
	output crs_vhigh_s             vhigh,
	output crs_misc_s              misc
);
	// ==========================================================
	// Registers
	logic [7:0] hsyncStart_q, hsyncEndDelay_q, vtotalLow_q, overflow_q, rowScanPan_q;
	logic       hsync_q, hsync_d;
	logic       vretrace_q;

	wire isHss = regReq.idx == IDX_HSYNC_START;
	wire isHse = regReq.idx == IDX_HSYNC_END;
	wire isVtl = regReq.idx == IDX_VTOTAL_LOW;
	wire isOvf = regReq.idx == IDX_VOVERFLOW;
	wire isRsp = regReq.idx == IDX_ROW_SCAN_PAN;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hsyncStart_q    <= REG_RESET; // see (R19)
			hsyncEndDelay_q <= REG_RESET;
			vtotalLow_q     <= REG_RESET;
			overflow_q      <= REG_RESET;
			rowScanPan_q    <= REG_RESET;
		end else if (regReq.wr) begin
			if (isHss) hsyncStart_q <= regReq.wdata;
			if (isHse) hsyncEndDelay_q <= regReq.wdata;
			if (isVtl) vtotalLow_q <= regReq.wdata;
			// No write protection: every bit incl. line compare 8 lands
			if (isOvf) overflow_q <= regReq.wdata; // see (R15)
			// Reserved bit 7 is dropped; software is trusted to write in retrace
			if (isRsp) rowScanPan_q <= regReq.wdata & ROW_SCAN_PAN_MASK; // see (R18)
		end
	end

	// ==========================================================
	// Read back
	assign regHit = isHss | isHse | isVtl | isOvf | isRsp;
	always_comb begin
		case (1'b1)
			isHss:   regRdata = hsyncStart_q;
			isHse:   regRdata = hsyncEndDelay_q;
			isVtl:   regRdata = vtotalLow_q;
			isOvf:   regRdata = overflow_q;
			isRsp:   regRdata = rowScanPan_q;
			default: regRdata = 8'h00;
		endcase
	end

	// ==========================================================
	// Horizontal sync, counted in character clocks
	wire [HEND_W-1:0] syncEnd = hsyncEndDelay_q[HEND_LSB +: HEND_W];
	wire startHit = charCount[7:0] == hsyncStart_q;           // see (R1) (R3)
	wire endHit   = charCount[HEND_W-1:0] == syncEnd;         // see (R7)

	// Start wins over end so a zero-width program still yields a pulse edge
	always_comb begin
		hsync_d = hsync_q;
		if (endHit)
			hsync_d = 1'b0;
		if (startHit)
			hsync_d = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			hsync_q <= 1'b0;
		else if (charTick)
			hsync_q <= hsync_d; // see (R3) (R7)
	end
	assign hsyncInt = hsync_q;

	crs_hsync_delay #(
		.DEPTH(3)
	) u_delay (
		.clk     (clk),
		.reset_n (reset_n),
		.charTick(charTick),
		.syncIn  (hsync_q),
		.delaySel(hsyncEndDelay_q[HDLY_LSB +: HDLY_W]),
		.syncOut (hsyncExt)
	); // see (R6)

	// ==========================================================
	// Vertical total, counted in scanlines
	assign vtotal = {overflow_q[OVF_VT9], overflow_q[OVF_VT8], vtotalLow_q}; // see (R10) (R11)

	// One pulse per match line, on the line tick where equality first holds
	wire vtHit = scanCount == vtotal; // see (R2) (R12)
	always_ff @(posedge clk) begin
		if (!reset_n)
			vretrace_q <= 1'b0;
		else if (lineTick)
			vretrace_q <= vtHit;
	end
	assign vretraceStart = lineTick & vtHit & ~vretrace_q; // see (R12)

	// ==========================================================
	// Overflow bits for the other vertical fields
	assign vhigh.vsyncStart9_8  = {overflow_q[OVF_VSS9], overflow_q[OVF_VSS8], 8'h00};  // see (R13)
	assign vhigh.vdisplayEnd9_8 = {overflow_q[OVF_VDE9], overflow_q[OVF_VDE8], 8'h00};  // see (R13)
	// Bit 9 comes from the cell height register outside
	assign vhigh.vblankStart8   = {1'b0, overflow_q[OVF_VBS8], 8'h00};  // see (R14)
	assign vhigh.lineCompare8   = {1'b0, overflow_q[OVF_LC8], 8'h00};   // see (R14)

	// ==========================================================
	// Row scan, pan and blanking end extension
	assign misc.presetRowScan  = rowScanPan_q[ROWSCAN_LSB +: ROWSCAN_W]; // see (R17)
	assign misc.coarsePanBytes = rowScanPan_q[PAN_LSB +: PAN_W];         // see (R16)
	assign misc.coarsePanPixels = {rowScanPan_q[PAN_LSB +: PAN_W], 3'b000}; // see (R16)
	assign misc.hblankEnd = {hsyncEndDelay_q[HBEND5_BIT], 5'b00000};    // see (R9)
endmodule : crs_crtc_timing

// ---- common/crs_pkg.sv ----
/*
 Package of the CRT sync, vertical total/overflow and row-scan/pan block:
 register indices, field positions, reset values and the carrier structs.
 Assumes an indexed 8-bit register port driven by the host interface logic.
*/
// Contract
// (R1) Horizontal positions count character clocks
// (R2) Vertical positions count scanlines
// (R3) Internal hsync starts at sync start match
// (R4) Software keeps sync start at or past display end
// (R5) Software leaves four clocks before horizontal total
// (R6) External hsync delayed zero to three clocks
// (R7) Low five counter bits end sync
// (R8) Software keeps sync within 31 clocks, blanking
// (R9) Sync end bit 7 is blanking end bit 5
// (R10) Vertical total is ten bits with overflow
// (R11) Software programs total scanlines minus two
// (R12) Retrace begins when scanline equals total
// (R13) Overflow supplies sync start, display end high bits
// (R14) Overflow supplies line compare, blank start bit 8
// (R15) Line compare bit always writable
// (R16) Coarse pan zero to three bytes
// (R17) First row starts at preset row scan
// (R18) Software changes row scan only in retrace
// (R19) All defined timing bits reset to zero
package crs_pkg;

	// ==========================================================
	// Register indices
	localparam logic [7:0] IDX_HSYNC_START  = 8'h04;
	localparam logic [7:0] IDX_HSYNC_END    = 8'h05;
	localparam logic [7:0] IDX_VTOTAL_LOW   = 8'h06;
	localparam logic [7:0] IDX_VOVERFLOW    = 8'h07;
	localparam logic [7:0] IDX_ROW_SCAN_PAN = 8'h08;

	// ==========================================================
	// Field positions
	localparam int HEND_LSB      = 0;
	localparam int HEND_W        = 5;
	localparam int HDLY_LSB      = 5;
	localparam int HDLY_W        = 2;
	localparam int HBEND5_BIT    = 7;
	localparam int OVF_VT8       = 0;
	localparam int OVF_VDE8      = 1;
	localparam int OVF_VSS8      = 2;
	localparam int OVF_VBS8      = 3;
	localparam int OVF_LC8       = 4;
	localparam int OVF_VT9       = 5;
	localparam int OVF_VDE9      = 6;
	localparam int OVF_VSS9      = 7;
	localparam int ROWSCAN_LSB   = 0;
	localparam int ROWSCAN_W     = 5;
	localparam int PAN_LSB       = 5;
	localparam int PAN_W         = 2;
	localparam int PIXELS_PER_BYTE_LOG2 = 3;
	localparam logic [7:0] ROW_SCAN_PAN_MASK = 8'h7f;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] idx;
		logic [7:0] wdata;
	} crs_regreq_s;

	typedef struct packed {
		logic [9:0] vsyncStart9_8;
		logic [9:0] vdisplayEnd9_8;
		logic [9:0] vblankStart8;
		logic [9:0] lineCompare8;
	} crs_vhigh_s;

	typedef struct packed {
		logic [4:0] presetRowScan;
		logic [1:0] coarsePanBytes;
		logic [4:0] coarsePanPixels;
		logic [5:0] hblankEnd;
	} crs_misc_s;

endpackage : crs_pkg

// ---- rtl/crs_hsync_delay.sv ----
/*
 Programmable 0..3 character-clock delay line for the external hsync.
 Assumes charTick marks one character clock in the clk domain.
*/
`timescale 1ns/1ps
module crs_hsync_delay
	import crs_pkg::*;
#(
	parameter int DEPTH = 3
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              charTick,
	input  wire logic              syncIn,
	input  wire logic [HDLY_W-1:0] delaySel,
	output logic                   syncOut
);
	logic [DEPTH:0] tap;
	logic [DEPTH-1:0] stage_q;

	assign tap[0] = syncIn;
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_stage
			always_ff @(posedge clk) begin
				if (!reset_n)
					stage_q[g] <= 1'b0;
				else if (charTick)
					stage_q[g] <= tap[g];
			end
			assign tap[g+1] = stage_q[g];
		end
	endgenerate

	// Zero delay passes through combinationally
	assign syncOut = tap[delaySel]; // see (R6)
endmodule : crs_hsync_delay

// ---- test/crs_crtc_timing_chk.sv ----
/* Port checker of the CRT timing block.
 Assumes it is bound onto crs_crtc_timing. */
`timescale 1ns/1ps
module crs_crtc_timing_chk
	import crs_pkg::*;
#(
	parameter int HCNT_W = 8,
	parameter int VCNT_W = 10
) (
	input wire logic              clk,
	input wire logic              reset_n,
	input wire crs_regreq_s       regReq,
	input wire logic              charTick,
	input wire logic [HCNT_W-1:0] charCount,
	input wire logic              lineTick,
	input wire logic [VCNT_W-1:0] scanCount,
	input wire logic              hsyncInt,
	input wire logic              hsyncExt,
	input wire logic              vretraceStart,
	input wire logic [VCNT_W-1:0] vtotal,
	input wire crs_vhigh_s        vhigh,
	input wire crs_misc_s         misc
);
	// ====
	// Shadows of writes, since registers are not visible here
	logic [7:0] wQ, wIdxQ, hsQ, heQ;
	wire        wrOk = reset_n && regReq.wr;
	always_ff @(posedge clk) begin
		wQ <= regReq.wdata;
		wIdxQ <= wrOk ? regReq.idx : 8'h00;
		hsQ <= !reset_n ? 8'h00 : (wrOk && regReq.idx == IDX_HSYNC_START) ? regReq.wdata : hsQ;
		heQ <= !reset_n ? 8'h00 : (wrOk && regReq.idx == IDX_HSYNC_END) ? regReq.wdata : heQ;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_vt_low; wIdxQ == IDX_VTOTAL_LOW |-> vtotal[7:0] == wQ; endproperty
	a_vt_low: assert property (p_vt_low) else $error("vtotal low byte wrong");
	property p_vt_high; wIdxQ == IDX_VOVERFLOW |-> vtotal[9:8] == {wQ[5], wQ[0]}; endproperty
	a_vt_high: assert property (p_vt_high) else $error("vtotal high bits wrong");
	property p_ovf_vs; wIdxQ == IDX_VOVERFLOW |-> vhigh.vsyncStart9_8[9:8] == {wQ[7], wQ[2]}
		&& vhigh.vdisplayEnd9_8[9:8] == {wQ[6], wQ[1]}; endproperty
	a_ovf_vs: assert property (p_ovf_vs) else $error("overflow routing wrong");
	property p_ovf_lc; wIdxQ == IDX_VOVERFLOW |-> vhigh.lineCompare8[8] == wQ[4]
		&& vhigh.vblankStart8[8] == wQ[3]; endproperty
	a_ovf_lc: assert property (p_ovf_lc) else $error("bit 8 routing wrong");
	property p_row; wIdxQ == IDX_ROW_SCAN_PAN |-> misc.presetRowScan == wQ[4:0]; endproperty
	a_row: assert property (p_row) else $error("row scan wrong");
	// Pan expected from the written byte, not from the block's own output
	property p_pan; wIdxQ == IDX_ROW_SCAN_PAN |-> misc.coarsePanBytes == wQ[6:5]
		&& misc.coarsePanPixels == {wQ[6:5], 3'b000}; endproperty
	a_pan: assert property (p_pan) else $error("pan pixels wrong");
	property p_hbend; wIdxQ == IDX_HSYNC_END |-> misc.hblankEnd[5] == wQ[7]; endproperty
	a_hbend: assert property (p_hbend) else $error("blank end bit wrong");
	property p_hs_on; charTick && charCount == hsQ |=> hsyncInt; endproperty
	a_hs_on: assert property (p_hs_on) else $error("sync did not start");
	property p_hs_off; charTick && charCount[4:0] == heQ[4:0] && charCount != hsQ
		|=> !hsyncInt; endproperty
	a_hs_off: assert property (p_hs_off) else $error("sync did not end");
	property p_dly0; heQ[6:5] == 2'b00 |-> hsyncExt == hsyncInt; endproperty
	a_dly0: assert property (p_dly0) else $error("undelayed sync differs");
	property p_vrs; vretraceStart |-> lineTick && scanCount == vtotal; endproperty
	a_vrs: assert property (p_vrs) else $error("retrace start off total");
endmodule : crs_crtc_timing_chk
bind crs_crtc_timing crs_crtc_timing_chk #(.HCNT_W(HCNT_W), .VCNT_W(VCNT_W)) u_chk (
	.clk, .reset_n, .regReq, .charTick, .charCount, .lineTick, .scanCount,
	.hsyncInt, .hsyncExt, .vretraceStart, .vtotal, .vhigh, .misc);

// ---- test/crs_display_model.sv ----
/* Display model: measures each received hsync pulse.
 Assumes one character clock per clk while sync runs. */
`timescale 1ns/1ps
module crs_display_model (
	input  wire logic  clk,
	input  wire logic  hsyncIn,
	output logic [7:0] lastWidth
);
	// ====
	// Pulse width in character clocks
	logic [7:0] runQ;
	always_ff @(posedge clk) begin
		runQ <= hsyncIn ? runQ + 8'h01 : 8'h00;
		if (!hsyncIn && runQ != 8'h00) begin
			lastWidth <= runQ;
		end
	end
endmodule : crs_display_model

// ---- test/tb.sv ----
/* Self-checking bench of the CRT timing block.
 Assumes the display model watches the external hsync. */
`timescale 1ns/1ps
module tb
	import crs_pkg::*;
;
	logic        clk = 1'b0, reset_n = 1'b0, charTick = 1'b0, lineTick = 1'b0;
	crs_regreq_s regReq = '0;
	logic [7:0]  charCount = 8'h00, regRdata, wid, v;
	logic [9:0]  scanCount = 10'h000, vtotal;
	logic        regHit, hsyncInt, hsyncExt, vretraceStart;
	crs_vhigh_s  vhigh;
	crs_misc_s   misc;
	int          n_errors = 0, checked = 0, ti, te;
	crs_crtc_timing DUT (.clk, .reset_n, .regReq, .regRdata, .regHit, .charTick, .charCount,
		.lineTick, .scanCount, .hsyncInt, .hsyncExt, .vretraceStart, .vtotal, .vhigh, .misc);
	crs_display_model u_disp (.clk, .hsyncIn(hsyncExt), .lastWidth(wid));
	initial forever #2.5 clk = ~clk;
	// ====
	// Access tasks
	task chk(input string n, input logic [19:0] s, e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] i, d);
		@(negedge clk);
		regReq = '{wr: 1'b1, rd: 1'b0, idx: i, wdata: d};
		@(negedge clk);
		regReq.wr = 1'b0;
	endtask : wr
	task rd(input logic [7:0] i, e);
		@(negedge clk);
		regReq.idx = i;
		regReq.rd = 1'b1;
		#1 chk("read", regRdata, e);
		chk("hit", regHit, 20'(i >= IDX_HSYNC_START && i <= IDX_ROW_SCAN_PAN));
		regReq.rd = 1'b0;
	endtask : rd
	task tally_and_finish;
		$display("Checks %0d, errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		for (int i = 4; i <= 9; i++) rd(8'(i), 8'h00);
		chk("unmapped hit", regHit, 1'b0);
		// Bit 7 of row scan/pan is not stored
		for (int i = 4; i <= 8; i++) begin
			wr(8'(i), 8'hff);
			rd(8'(i), i == 8 ? 8'h7f : 8'hff);
		end
		// Totals kept as scanlines minus two by the programming side
		for (int k = 0; k < 2; k++) begin
			v = k ? 8'h5a : 8'ha5;
			wr(IDX_VOVERFLOW, v);
			wr(IDX_VTOTAL_LOW, ~v);
			chk("vtotal", vtotal, {v[5], v[0], ~v});
			chk("vss", vhigh.vsyncStart9_8, {v[7], v[2], 8'h00});
			chk("vde", vhigh.vdisplayEnd9_8, {v[6], v[1], 8'h00});
			chk("lc vbs", {vhigh.lineCompare8[9:8], vhigh.vblankStart8[9:8]},
				{1'b0, v[4], 1'b0, v[3]});
		end
		scanCount = {v[5], v[0], ~v};
		lineTick = 1'b1;
		#1 chk("retrace", vretraceStart, 1'b1);
		@(negedge clk) chk("retrace once", vretraceStart, 1'b0);
		lineTick = 1'b0;
		for (int p = 0; p < 4; p++) begin
			// Row scan rewritten while the bench treats the frame as in retrace
			wr(IDX_ROW_SCAN_PAN, {1'b1, 2'(p), 5'(p + 17)});
			chk("pan", misc, {5'(p + 17), 2'(p), 5'(p * 8), 6'h20});
		end
		// Sync start 0x50, end 0x1a: ten characters wide
		wr(IDX_HSYNC_START, 8'h50);
		for (int d = 0; d < 4; d++) begin
			wr(IDX_HSYNC_END, {1'b0, 2'(d), 5'h1a});
			ti = -1;
			te = -1;
			charCount = 8'h40;
			charTick = 1'b1;
			for (int i = 0; i < 200; i++) begin
				@(negedge clk);
				if (hsyncInt && ti < 0) ti = i;
				if (hsyncExt && te < 0) te = i;
				charCount = charCount + 8'h01;
			end
			chk("ext delay", 20'(te - ti), 20'(d));
			chk("width", wid, 8'd10);
			charTick = 1'b0;
		end
		tally_and_finish;
	end
endmodule : tb
